// [hw/swlp_defs.svh]
`ifndef SWLP_DEFS_SVH
`define SWLP_DEFS_SVH
`define SWLP_WORD_W      32
`define SWLP_CODE_W      3
`define SWLP_NUM_REGS    8
`define SWLP_CNT_W       6
`define SWLP_PD_BIT      5
`define SWLP_REG_RST     32'h0000_0000
`define SWLP_SYNC_DEPTH  3
`define SWLP_PD_REG      2
`endif

// [hw/swlp_pkg.sv]
`default_nettype none
package swlp_pkg;
    typedef struct packed {
        logic [31:0] word;
        logic [2:0]  code;
    } swlp_load_type;
    typedef struct packed {
        logic powered;
        logic pump_enable;
    } swlp_power_type;
endpackage
`default_nettype wire

// [hw/swlp_port.sv]
`include "swlp_defs.svh"
`default_nettype none
// Notes on behaviour
// [RULE_01] shift data into a 32-bit register on each rising serial clock edge
// [RULE_02] first bit shifted in ends up as the word's top bit
// [RULE_03] three lowest word bits select the destination register
// [RULE_04] rising latch strobe copies the shift register to the selected register
// [RULE_05] chip enable low powers down and floats the pump output
// [RULE_06] chip enable high powers up unless power-down bits hold functions off
// [RULE_07] host keeps strobe low while shifting and sends exactly 32 bits
module swlp_port #(
    parameter int WORD_W = `SWLP_WORD_W
) (
    input  wire logic                    clock,        // system clock, 40 MHz
    input  wire logic                    reset,        // sync reset, active high
    input  wire logic                    serial_clock, // link clock from host
    input  wire logic                    serial_data,  // serial data in
    input  wire logic                    latch_strobe, // load strobe pin
    input  wire logic                    chip_enable,  // chip enable pin
    output logic [`SWLP_NUM_REGS*WORD_W-1:0] regs_out, // all loaded registers
    output logic [`SWLP_NUM_REGS-1:0]    load_pulse,   // one-cycle per-register load flag
    output logic                         powered,      // device powered up
    output logic                         pump_output_oe // pump output driven
);
    localparam int CODE_W   = `SWLP_CODE_W;
    localparam int NUM_REGS = `SWLP_NUM_REGS;
    localparam int SYNC_N   = `SWLP_SYNC_DEPTH;
    localparam int NUM_PINS = 2;
    localparam int PIN_LS   = 0;
    localparam int PIN_CE   = 1;
    localparam int PD_INDEX = `SWLP_PD_REG * WORD_W + `SWLP_PD_BIT;

    // carrier struct and code decode assume the 32-bit word
    generate
        if (WORD_W != `SWLP_WORD_W) begin : g_bad_word
            $error("swlp_port: WORD_W must be 32");
        end
        if (SYNC_N < 3) begin : g_bad_sync
            $error("swlp_port: pin synchroniser needs three stages");
        end
    endgenerate

    // one decode shared by the load flag and the register write
    function automatic logic code_hit(
        input logic [CODE_W-1:0] code,
        input int                index
    );
        logic [CODE_W-1:0] want;
        want     = index[CODE_W-1:0];
        code_hit = (code == want);
    endfunction

    // ------------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------------

    // no reset: the host may leave its clock stopped for good
    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] nxt_shift;

    always_comb begin
        nxt_shift = {shift_ff[WORD_W-2:0], serial_data}; // RULE_02
    end

    always_ff @(posedge serial_clock) begin
        shift_ff <= nxt_shift; // RULE_01
    end

    // ------------------------------------------------------------------
    // pin synchronisers, system clock domain
    // ------------------------------------------------------------------

    wire logic [NUM_PINS-1:0] pin_raw;
    wire logic [NUM_PINS-1:0] pin_last;
    wire logic [NUM_PINS-1:0] pin_settled;
    wire logic [NUM_PINS-1:0] pin_level;

    assign pin_raw[PIN_LS] = latch_strobe;
    assign pin_raw[PIN_CE] = chip_enable;

    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++) begin : g_pin
            logic [SYNC_N-1:0] sync_ff;
            logic              level_ff;

            // only the second stage reads the first
            always_ff @(posedge clock) begin
                if (reset) begin
                    sync_ff <= '0;
                end else begin
                    sync_ff <= {sync_ff[SYNC_N-2:0], pin_raw[p]};
                end
            end

            assign pin_last[p]    = sync_ff[SYNC_N-1];
            assign pin_settled[p] = (sync_ff[SYNC_N-1] == sync_ff[SYNC_N-2]);

            // starts low like the idle pin, so no false edge after reset
            always_ff @(posedge clock) begin
                if (reset) begin
                    level_ff <= 1'b0;
                end else if (pin_settled[p]) begin
                    level_ff <= sync_ff[SYNC_N-1];
                end
            end

            assign pin_level[p] = level_ff;
        end
    endgenerate

    // ------------------------------------------------------------------
    // strobe edge and word transfer
    // ------------------------------------------------------------------

    logic strobe_rise;

    always_comb begin
        strobe_rise = pin_settled[PIN_LS] && pin_last[PIN_LS] && !pin_level[PIN_LS];
    end

    // settled strobe is the handshake: serial clock is held still from the
    // last bit until the strobe has been high four cycles, so the word is quiet
    swlp_pkg::swlp_load_type nxt_load;

    always_comb begin
        nxt_load.word = shift_ff;
        nxt_load.code = shift_ff[CODE_W-1:0]; // RULE_03
    end

    // ------------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------------

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            logic hit;

            always_comb begin
                hit = strobe_rise && code_hit(nxt_load.code, g); // RULE_03
            end

            always_ff @(posedge clock) begin
                if (reset) begin
                    regs_out[g*WORD_W +: WORD_W] <= `SWLP_REG_RST;
                end else if (hit) begin
                    regs_out[g*WORD_W +: WORD_W] <= nxt_load.word; // RULE_04
                end
            end

            always_ff @(posedge clock) begin
                if (reset) begin
                    load_pulse[g] <= 1'b0;
                end else begin
                    load_pulse[g] <= hit; // RULE_04
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // power control
    // ------------------------------------------------------------------

    // power-down bit is a bit of register 2; powered follows chip enable only
    swlp_pkg::swlp_power_type nxt_power;

    always_comb begin
        nxt_power.powered     = pin_level[PIN_CE]; // RULE_05 RULE_06
        nxt_power.pump_enable = pin_level[PIN_CE] && !regs_out[PD_INDEX]; // RULE_05 RULE_06
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            powered <= 1'b0;
        end else begin
            powered <= nxt_power.powered; // RULE_05 RULE_06
        end
    end

    // low oe means the pump output floats
    always_ff @(posedge clock) begin
        if (reset) begin
            pump_output_oe <= 1'b0;
        end else begin
            pump_output_oe <= nxt_power.pump_enable; // RULE_05 RULE_06
        end
    end

endmodule // swlp_port
`default_nettype wire

// [sim/swlp_port_props.sv]
`default_nettype none
module swlp_port_props (
    input wire logic         clock,          // system clock
    input wire logic         reset,          // sync reset, active high
    input wire logic         latch_strobe,   // load strobe pin
    input wire logic         chip_enable,    // chip enable pin
    input wire logic [255:0] regs_out,       // loaded registers
    input wire logic [7:0]   load_pulse,     // per-register load flag
    input wire logic         powered,        // device powered up
    input wire logic         pump_output_oe  // pump output driven
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_rise; !latch_strobe ##1 latch_strobe; endsequence
    sequence s_pulse; load_pulse != 8'h00; endsequence
    property p_load; s_rise |-> ##[2:5] s_pulse; endproperty
    property p_short; s_pulse |=> load_pulse == 8'h00; endproperty
    a_short: assert property (p_short) else $error("load flag held");
    property p_hold; !$stable(regs_out) |-> s_pulse; endproperty
    a_hold: assert property (p_hold) else $error("register changed without load");
    property p_pd; regs_out[69] |=> !pump_output_oe; endproperty
    a_pd: assert property (p_pd) else $error("pump driven while powered down");
    a_load: assert property (p_load) else $error("no load pulse");
    property p_one; $onehot0(load_pulse); endproperty
    a_one: assert property (p_one) else $error("two registers loaded");
    property p_off; !chip_enable [*8] |-> !powered && !pump_output_oe; endproperty
    a_off: assert property (p_off) else $error("awake while disabled");
    property p_on; chip_enable [*8] |-> powered; endproperty
    a_on: assert property (p_on) else $error("not powered");
endmodule // swlp_port_props
bind swlp_port swlp_port_props chk (.clock(clock), .reset(reset), .latch_strobe(latch_strobe),
    .chip_enable(chip_enable), .regs_out(regs_out), .load_pulse(load_pulse), .powered(powered),
    .pump_output_oe(pump_output_oe));
`default_nettype wire

// [sim/swlp_host.sv]
`default_nettype none
module swlp_host (
    output logic sclk,   // link clock
    output logic sdat,   // serial data
    output logic strobe  // load strobe
);
    timeunit 1ns; timeprecision 100ps;
    initial begin sclk = 0; sdat = 0; strobe = 0; end
    // link clock idles low between words; data flips after use
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            sdat = w[i]; #40 sclk = 1; #40 sclk = 0;
        end
        sdat = ~sdat; #40 strobe = 1;
        #200 strobe = 0; #200;
    endtask
endmodule // swlp_host
`default_nettype wire

// [sim/swlp_port_bench.sv]
`default_nettype none
module swlp_port_bench;
    timeunit 1ns; timeprecision 100ps;
    logic clock = 0, reset = 1, chip_enable = 0, powered, oe, sclk, sdat, strobe;
    logic [255:0] regs; logic [7:0] pulse;
    int n_errors = 0, n_checks = 0, cyc = 0;
    logic [7:0] seen = 8'h00;
    always @(posedge clock) if (!reset) seen <= seen | pulse;
    swlp_host hst (.sclk(sclk), .sdat(sdat), .strobe(strobe));
    swlp_port uut (.clock(clock), .reset(reset), .serial_clock(sclk), .serial_data(sdat),
        .latch_strobe(strobe), .chip_enable(chip_enable), .regs_out(regs),
        .load_pulse(pulse), .powered(powered), .pump_output_oe(oe));
    initial forever #12.5 clock = ~clock;
    always @(posedge clock) if (++cyc > 5000) begin n_errors++; finish_test(); end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin n_errors++; $display("Error %0t %h %h", $time, got, exp); end
    endtask
    task automatic t_load;
        for (int i = 0; i < 8; i++) begin
            hst.send(32'hc3a5_0000 | (i << 8) | i);
            chk(regs[i*32 +: 32], 32'hc3a5_0000 | (i << 8) | i);
        end
        chk(regs[31:0], 32'hc3a5_0000);
        chk(seen, 32'h0000_00ff);
    endtask
    task automatic t_reset;
        @(negedge clock) reset = 1;
        repeat (2) @(negedge clock);
        chk(regs[95:64], 32'h0000_0000);
        chk({pulse, powered, oe}, 32'h0000_0000);
        reset = 0;
        repeat (8) @(negedge clock);
        chk({powered, oe}, 32'h0000_0003);
        hst.send(32'h8000_0005);
        chk(regs[5*32 +: 32], 32'h8000_0005);
    endtask
    task automatic t_power;
        @(negedge clock) chip_enable = 0;
        repeat (8) @(negedge clock);
        chk({powered, oe}, 32'h0000_0000);
        chip_enable = 1;
        repeat (8) @(negedge clock);
        chk({powered, oe}, 32'h0000_0003);
        hst.send(32'h0000_0022);
        @(negedge clock) chk({powered, oe}, 32'h0000_0002);
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clock);
        reset = 0; chip_enable = 1;
        t_load(); t_power(); t_reset(); finish_test();
    end
endmodule // swlp_port_bench
`default_nettype wire
